// ===== inc/bit_branch_pkg.sv
// Notes on behaviour
// - Bit clear zeroes bit b (0..7) of register f (0..127); no flags change.
// - Bit set forces bit b of register f to one; no flags change.
// - Skip-if-zero skips next instruction when bit is zero; two cycles then.
// - Skip-if-one skips next instruction when bit is one; two cycles then.
// - Relative jump loads counter with incremented counter plus signed 9-bit offset.
// - Accumulator jump adds unsigned working value to incremented counter; two cycles.
// - One instruction cycle equals four oscillator clocks; counts use that unit.
`default_nettype none
package bit_branch_pkg;
    localparam int PC_WIDTH         = 15;
    localparam int WORD_WIDTH       = 14;
    localparam int ADDR_WIDTH       = 7;
    localparam int CLOCKS_PER_CYCLE = 4;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 15'h0000;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] PHASE_LAST  = 2'(CLOCKS_PER_CYCLE - 1);
    // Opcode fields of the 14-bit word
    localparam int OP_HI  = 13;
    localparam int OP_LO  = 10;
    localparam int BIT_HI = 9;
    localparam int BIT_LO = 7;
    localparam int K_HI   = 8;
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET   = 4'h5;
    localparam logic [3:0] OPC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OPC_SKIP_ONE  = 4'h7;
    localparam logic [4:0] OPC_REL_JUMP  = 5'h19;
    localparam logic [13:0] OPC_ACC_JUMP = 14'h000b;
    typedef enum logic [5:0] {
        NONE_OP                = 6'h01,
        BIT_CLEAR_OP           = 6'h02,
        BIT_SET_OP             = 6'h04,
        TEST_SKIP_IF_ZERO_OP   = 6'h08,
        TEST_SKIP_IF_ONE_OP    = 6'h10,
        JUMP_OP                = 6'h20
    } op_class_type;
endpackage
`default_nettype wire

// ===== inc/decode_if.sv
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    logic [13:0]                   word;
    bit_branch_pkg::op_class_type  op_class;
    logic [2:0]                    bit_sel;
    logic [6:0]                    addr;
    logic [14:0]                   offset;
    modport decoder (input word, output op_class, bit_sel, addr, offset);
    modport core (output word, input op_class, bit_sel, addr, offset);
endinterface
`default_nettype wire

// ===== hw/op_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module op_decoder (
    decode_if.decoder dec,
    input  wire logic [7:0] acc_value
);
    always_comb begin
        dec.op_class = bit_branch_pkg::NONE_OP;
        dec.bit_sel  = dec.word[bit_branch_pkg::BIT_HI:bit_branch_pkg::BIT_LO];
        dec.addr     = dec.word[bit_branch_pkg::ADDR_WIDTH-1:0];
        dec.offset   = '0;
        unique case (dec.word[bit_branch_pkg::OP_HI:bit_branch_pkg::OP_LO])
            bit_branch_pkg::OPC_BIT_CLEAR: dec.op_class = bit_branch_pkg::BIT_CLEAR_OP;
            bit_branch_pkg::OPC_BIT_SET:   dec.op_class = bit_branch_pkg::BIT_SET_OP;
            bit_branch_pkg::OPC_SKIP_ZERO: dec.op_class = bit_branch_pkg::TEST_SKIP_IF_ZERO_OP;
            bit_branch_pkg::OPC_SKIP_ONE:  dec.op_class = bit_branch_pkg::TEST_SKIP_IF_ONE_OP;
            default: begin
                if (dec.word[13:9] == bit_branch_pkg::OPC_REL_JUMP) begin
                    dec.op_class = bit_branch_pkg::JUMP_OP;
                    // Sign-extended 9-bit offset, -256..255
                    dec.offset   = {{6{dec.word[bit_branch_pkg::K_HI]}}, dec.word[8:0]};
                end else if (dec.word == bit_branch_pkg::OPC_ACC_JUMP) begin
                    dec.op_class = bit_branch_pkg::JUMP_OP;
                    dec.offset   = {7'h00, acc_value};
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hw/bit_op_branch_exec.sv
`timescale 1ns/1ps
`default_nettype none
module bit_op_branch_exec (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [13:0] instr_word,
    input  wire logic [7:0]  file_rdata,
    input  wire logic [7:0]  acc_value,
    output logic      [14:0] prog_addr,
    output logic      [6:0]  file_addr,
    output logic      [7:0]  file_wdata,
    output logic             file_we,
    output logic             cycle_strobe,
    output logic             squash
);
    decode_if dif ();

    logic [1:0]  phase_reg;
    logic [1:0]  phase_next;
    logic [14:0] pc_reg;
    logic [14:0] pc_next;
    logic [13:0] ir_reg;
    logic [13:0] ir_next;
    logic        flush_reg;
    logic        flush_next;
    logic [6:0]  faddr_reg;
    logic [6:0]  faddr_next;
    logic [7:0]  wdata_reg;
    logic [7:0]  wdata_next;
    logic        we_reg;
    logic        we_next;
    logic        strobe_reg;
    logic        strobe_next;
    logic        end_cycle;
    logic        retire_valid;
    logic        bit_value;
    logic        take;
    logic        write_req;
    logic [7:0]  write_value;
    logic [14:0] fall_through;
    logic [14:0] jump_target;
    logic [7:0]  bit_mask;
    logic [7:0]  cleared_data;
    logic [7:0]  set_data;

    assign dif.word = ir_reg;

    op_decoder i_op_decoder (
        .dec       (dif.decoder),
        .acc_value (acc_value)
    );

    // Last of the four clocks in an instruction cycle
    assign end_cycle    = (phase_reg == bit_branch_pkg::PHASE_LAST);
    // A squashed slot retires as a no-op
    assign retire_valid = end_cycle && !flush_reg;
    assign bit_value    = file_rdata[dif.bit_sel];
    assign fall_through = pc_reg + 15'h0001;

    // Read-modify-write lanes, one per data bit
    for (genvar i = 0; i < 8; i++) begin : bit_lane
        assign bit_mask[i]     = (dif.bit_sel == 3'(i));
        assign cleared_data[i] = file_rdata[i] & ~bit_mask[i];
        assign set_data[i]     = file_rdata[i] | bit_mask[i];
    end

    // Outcome of the instruction now retiring
    always_comb begin
        take        = 1'b0;
        write_req   = 1'b0;
        write_value = wdata_reg;
        jump_target = fall_through;
        unique case (dif.op_class)
            bit_branch_pkg::BIT_CLEAR_OP: begin
                write_req   = 1'b1;
                write_value = cleared_data;
            end
            bit_branch_pkg::BIT_SET_OP: begin
                write_req   = 1'b1;
                write_value = set_data;
            end
            bit_branch_pkg::TEST_SKIP_IF_ZERO_OP: begin
                take = !bit_value;
            end
            bit_branch_pkg::TEST_SKIP_IF_ONE_OP: begin
                take = bit_value;
            end
            bit_branch_pkg::JUMP_OP: begin
                take        = 1'b1;
                // pc_reg already points past this instruction
                jump_target = pc_reg + dif.offset;
            end
            bit_branch_pkg::NONE_OP: begin
                take = 1'b0;
            end
        endcase
    end

    // Phase counter
    always_comb begin
        phase_next = phase_reg + 2'h1;
        if (end_cycle) begin
            phase_next = bit_branch_pkg::PHASE_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= bit_branch_pkg::PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Fetch address moves once per instruction cycle
    always_comb begin
        pc_next = pc_reg;
        if (end_cycle) begin
            pc_next = fall_through;
        end
        if (retire_valid) begin
            pc_next = jump_target;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= bit_branch_pkg::PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // Fetch latch
    always_comb begin
        ir_next = ir_reg;
        if (end_cycle) begin
            ir_next = instr_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_reg <= 14'h0000;
        end else begin
            ir_reg <= ir_next;
        end
    end

    // Reset leaves the pipeline empty: first slot is a no-op
    always_comb begin
        flush_next = flush_reg;
        if (end_cycle) begin
            flush_next = 1'b0;
        end
        if (retire_valid) begin
            // Fetched word becomes a no-op cycle when take is set
            flush_next = take;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_reg <= 1'b1;
        end else begin
            flush_reg <= flush_next;
        end
    end

    // Register address tracks the instruction in execution
    always_comb begin
        faddr_next = dif.addr;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faddr_reg <= 7'h00;
        end else begin
            faddr_reg <= faddr_next;
        end
    end

    // Write pulse lasts one clock
    always_comb begin
        wdata_next = wdata_reg;
        we_next    = 1'b0;
        if (retire_valid && write_req) begin
            wdata_next = write_value;
            we_next    = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_reg <= 8'h00;
            we_reg    <= 1'b0;
        end else begin
            wdata_reg <= wdata_next;
            we_reg    <= we_next;
        end
    end

    // One-clock pulse in the first clock after each instruction cycle end
    always_comb begin
        strobe_next = end_cycle;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    assign prog_addr    = pc_reg;
    assign file_addr    = faddr_reg;
    assign file_wdata   = wdata_reg;
    assign file_we      = we_reg;
    assign cycle_strobe = strobe_reg;
    assign squash       = flush_reg;
endmodule
`default_nettype wire

// ===== verification/bit_op_branch_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module bit_op_branch_exec_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [13:0] instr_word,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  acc_value,
    input wire logic [14:0] prog_addr,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic        cycle_strobe,
    input wire logic        squash
);
    wire logic [3:0]  op  = instr_word[13:10];
    wire logic [4:0]  op5 = instr_word[13:9];
    wire logic [7:0]  msk = 8'h01 << instr_word[9:7];
    wire logic [14:0] k15 = {{6{instr_word[8]}}, instr_word[8:0]};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_strobe_period: assert property (cycle_strobe |=> !cycle_strobe [*3] ##1 cycle_strobe)
        else $error("strobe period");
    a_pc_moves_late: assert property (!$stable(prog_addr) |-> cycle_strobe)
        else $error("pc moved mid cycle");
    a_bit_write: assert property (file_we |-> file_wdata == ($past(op, 5) == 4'h5 ?
        $past(file_rdata) | $past(msk, 5) :
        $past(file_rdata) & ~$past(msk, 5))) else $error("wdata");
    a_squash_no_write: assert property (cycle_strobe && $past(squash) |-> !file_we)
        else $error("squashed write");
    a_skip_zero: assert property (cycle_strobe && !$past(squash) && $past(op, 5) == 4'h6
        |-> squash != |($past(file_rdata) & $past(msk, 5))) else $error("skip zero");
    a_skip_one: assert property (cycle_strobe && !$past(squash) && $past(op, 5) == 4'h7
        |-> squash == |($past(file_rdata) & $past(msk, 5))) else $error("skip one");
    a_rel_jump: assert property (cycle_strobe && !$past(squash) && $past(op5, 5) == 5'h19
        |-> squash && prog_addr == $past(prog_addr) + $past(k15, 5)) else $error("jump");
    a_acc_jump: assert property (cycle_strobe && !$past(squash)
        && $past(instr_word, 5) == 14'h000b
        |-> squash && prog_addr == $past(prog_addr) + $past(acc_value)) else $error("acc jump");
    cover property (file_we);
    cover property ($rose(squash));
    cover property (cycle_strobe && $past(instr_word, 5) == 14'h000b);
endmodule
bind bit_op_branch_exec bit_op_branch_exec_props i_props (.clk(clk), .rst_n(rst_n),
    .instr_word(instr_word), .file_rdata(file_rdata), .acc_value(acc_value),
    .prog_addr(prog_addr), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_we(file_we), .cycle_strobe(cycle_strobe), .squash(squash));
`default_nettype wire

// ===== verification/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        clk,
    input  wire logic [14:0] prog_addr,
    input  wire logic [6:0]  file_addr,
    input  wire logic [7:0]  file_wdata,
    input  wire logic        file_we,
    output logic      [13:0] instr_word,
    output logic      [7:0]  file_rdata
);
    logic [13:0] rom [512];
    logic [7:0]  regs [128];
    assign instr_word = rom[prog_addr[8:0]];
    assign file_rdata = regs[file_addr];
    always @(posedge clk) begin
        if (file_we) begin
            regs[file_addr] <= file_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== verification/bit_op_branch_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module bit_op_branch_exec_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  acc_value = 8'h00;
    logic [13:0] instr_word;
    logic [7:0]  file_rdata;
    logic [7:0]  file_wdata;
    logic [14:0] prog_addr;
    logic [6:0]  file_addr;
    logic        file_we;
    logic        cycle_strobe;
    logic        squash;
    int          err_count = 0;
    int          cmp_count = 0;
    always #20 clk = ~clk;
    bit_op_branch_exec i_bit_op_branch_exec (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
        .file_rdata(file_rdata), .acc_value(acc_value), .prog_addr(prog_addr),
        .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
        .cycle_strobe(cycle_strobe), .squash(squash));
    mem_model i_mem_model (.clk(clk), .prog_addr(prog_addr), .file_addr(file_addr),
        .file_wdata(file_wdata), .file_we(file_we), .instr_word(instr_word),
        .file_rdata(file_rdata));
    task automatic results;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [6:0] a, input logic [7:0] exp);
        cmp_count++;
        if (i_mem_model.regs[a] !== exp) begin
            err_count++;
            $display("BAD %0t reg %0h got %0h", $time, a, i_mem_model.regs[a]);
        end
    endtask
    task automatic restart(input logic [13:0] p [9]);
        @(posedge clk) #1 rst_n = 1'b0;
        for (int i = 0; i < 512; i++) i_mem_model.rom[i] = (i < 9) ? p[i] : 14'h0000;
        for (int i = 0; i < 128; i++) i_mem_model.regs[i] = 8'h00;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic run(input int n);
        int seen = 0;
        for (int c = 0; c < 8 * n && seen < n; c++) begin
            @(posedge clk) #1;
            if (cycle_strobe === 1'b1) seen++;
        end
        if (seen < n) begin
            err_count++;
            $display("BAD %0t no strobe", $time);
            results();
        end
    endtask
    task automatic t_bits;
        restart('{14'h1505, 14'h1006, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
            14'h0000, 14'h0000});
        i_mem_model.regs[6] = 8'hff;
        run(4);
        chk(7'h05, 8'h04);
        chk(7'h06, 8'hfe);
    endtask
    task automatic t_skip;
        restart('{14'h1887, 14'h1408, 14'h1c07, 14'h1488, 14'h1807, 14'h1508, 14'h1c87,
            14'h1588, 14'h0000});
        i_mem_model.regs[7] = 8'h01;
        run(12);
        chk(7'h08, 8'h0c);
    endtask
    task automatic t_jump;
        restart('{14'h3203, 14'h1409, 14'h1489, 14'h0000, 14'h000b, 14'h1509, 14'h1589,
            14'h1609,
            14'h33fe});
        acc_value = 8'h02;
        run(20);
        chk(7'h09, 8'h10);
    endtask
    initial begin
        t_bits();
        t_skip();
        t_jump();
        results();
    end
endmodule
`default_nettype wire
